// ===== dv/serdes_pcs_status_counters_monitor.sv
// Port-level assertion checker for the SerDes PCS register bank
`default_nettype none
`include "serdes_pcs_regs.vh"

module serdes_pcs_status_counters_monitor (
  input wire logic        i_clk_sys,
  input wire logic        i_sys_rst,
  input wire logic [4:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic        o_fwd_rd,
  input wire logic [2:0]  o_fwd_space,
  input wire logic [15:0] i_fwd_rdata,
  input wire logic [15:0] i_an_adv_word,
  input wire logic [15:0] o_adv_word,
  input wire logic        o_force_adv,
  input wire logic [3:0]  i_comma_pos
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] page_r;

  // --------------------------------------------------------------
  // Page shadow
  // --------------------------------------------------------------
  // Register 31 is always local, so the shadow never drifts
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) page_r <= `RST_PAGE_SEL;
    else if (i_wr && i_addr == `REG_PAGE_SEL) page_r <= i_wdata;
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  // --------------------------------------------------------------
  // Decode and data path
  // --------------------------------------------------------------
  low_regs_a: assert property (i_rd && i_addr < `REG_PAGED_LO |-> o_fwd_rd && o_fwd_space == `SPACE_MAIN)
    else $error("low register not in main space");
  page4_csr_a: assert property (i_rd && page_r == `PAGE_EXT4 && i_addr inside {[5'h10:5'h14]}
    |-> o_fwd_rd && o_fwd_space == `SPACE_P4_CSR) else $error("page 4 CSR decode wrong");
  page4_pps_a: assert property (i_rd && page_r == `PAGE_EXT4 && i_addr == `P4_PPS
    |-> o_fwd_rd && o_fwd_space == `SPACE_P4_PPS) else $error("page 4 PPS decode wrong");
  page4_rsvd_a: assert property (i_rd && page_r == `PAGE_EXT4 && i_addr inside {[5'h16:5'h19]}
    |-> !o_fwd_rd ##1 o_rdata == 16'h0000) else $error("page 4 reserved not zero");
  page4_upper_a: assert property (i_rd && page_r == `PAGE_EXT4 && i_addr inside {[5'h1a:5'h1e]}
    |-> o_fwd_space == (i_addr <= `P4_SPI_LAST ? `SPACE_P4_SPI : `SPACE_P4_REFCLK)) else $error("page 4 upper decode");
  page_main_a: assert property (i_rd && page_r == `PAGE_MAIN && i_addr inside {[5'h10:5'h1e]}
    |-> o_fwd_rd && o_fwd_space == `SPACE_MAIN) else $error("page 0 not main space");
  fwd_data_a: assert property (o_fwd_rd |=> o_rdata == $past(i_fwd_rdata))
    else $error("forwarded read data lost");
  comma_pos_a: assert property (i_rd && page_r == `PAGE_EXT3 && i_addr == `REG_LINK_FLAGS
    |=> o_rdata[11:8] == $past(i_comma_pos) && o_rdata[6:0] == 7'h00) else $error("flag word fields wrong");

  // --------------------------------------------------------------
  // Advertised word control
  // --------------------------------------------------------------
  adv_pass_a: assert property (!o_force_adv |-> o_adv_word == i_an_adv_word)
    else $error("unforced advertised word not from engine");
  adv_hold_a: assert property (o_force_adv && $past(o_force_adv) && $changed(o_adv_word)
    |-> $past(i_wr) && $past(i_addr) == `REG_ADV_WORD) else $error("forced word moved without write");
  force_write_a: assert property ($changed(o_force_adv) |-> $past(i_wr) && $past(i_addr) == `REG_PCS_CTRL)
    else $error("force bit moved without write");
endmodule

bind serdes_pcs_status_counters serdes_pcs_status_counters_monitor mon (.i_clk_sys, .i_sys_rst, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .o_fwd_rd, .o_fwd_space, .i_fwd_rdata, .i_an_adv_word, .o_adv_word,
  .o_force_adv, .i_comma_pos);
`default_nettype wire

// ===== dv/serdes_pcs_status_counters_tb.sv
// Self-checking bench for the SerDes PCS register bank
`default_nettype none
`include "serdes_pcs_regs.vh"

module serdes_pcs_status_counters_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk_sys, i_sys_rst, i_wr, i_rd, i_partner_valid, i_comma_detect, i_media_link_up, o_force_adv;
  logic [4:0]  i_addr;
  logic [3:0]  i_comma_pos, flg, crc;
  logic [15:0] i_wdata, o_rdata, i_fwd_rdata, i_an_adv_word, o_adv_word, i_partner_word, o_fwd_wdata;
  logic        o_fwd_wr, o_fwd_rd;
  logic [2:0]  o_fwd_space;
  logic [4:0]  o_fwd_addr;
  int          num_errors, checked, cycles;

  // Flag vector is {hls, fefi, signal detect, realign}; crc is {mac bad, mac good, fiber bad, fiber good}
  serdes_pcs_status_counters DUT (.i_clk_sys, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_fwd_wr, .o_fwd_rd, .o_fwd_space, .o_fwd_addr, .o_fwd_wdata, .i_fwd_rdata, .i_an_adv_word,
    .o_adv_word, .o_force_adv, .i_partner_valid, .i_partner_word, .i_comma_realign(flg[0]),
    .i_signal_detect(flg[1]), .i_fefi_rx(flg[2]), .i_comma_detect, .i_comma_pos, .i_hls_rx(flg[3]),
    .i_media_link_up, .i_fiber_crc_good(crc[0]), .i_fiber_crc_bad(crc[1]), .i_mac_crc_good(crc[2]),
    .i_mac_crc_bad(crc[3]));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Strobes drop at the following edge, so two calls always leave one idle cycle
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  // Read data only stands in the cycle after the strobe
  task automatic rc(input logic [4:0] a, input logic [15:0] exp);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 check($sformatf("reg %h", a), o_rdata, exp);
  endtask

  // Write that must leave the bank; forward lines are judged while the strobe stands
  task automatic fw(input logic [4:0] a, input logic [2:0] sp);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= 16'h5a5a;
    i_wr <= 1'b1;
    #1 check($sformatf("fwd %h", a), {o_fwd_wr, o_fwd_rd, o_fwd_space, o_fwd_addr}, {2'b10, sp, a});
    check("fwd wdata", o_fwd_wdata, 16'h5a5a);
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  // Packets spaced by an idle cycle, one strobe each
  task automatic pk(input logic [3:0] v, input int n);
    repeat (n) begin
      @(posedge i_clk_sys);
      crc <= v;
      @(posedge i_clk_sys);
      crc <= 4'h0;
    end
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset;
    wr(`REG_PAGE_SEL, `PAGE_EXT3);
    rc(`REG_PAGE_SEL, `PAGE_EXT3);
    fw(5'h0a, `SPACE_MAIN);
    rc(`REG_PARTNER_WORD, `RST_PARTNER_WORD);
    rc(`REG_LINK_FLAGS, 16'h0000);
    rc(`REG_GOOD_CRC, 16'h0000);
    rc(`REG_BAD_CRC, 16'h0000);
  endtask

  task automatic t_adv;
    rc(`REG_ADV_WORD, 16'h3c5a);
    wr(`REG_ADV_WORD, 16'h1234);
    #1 check("adv out", o_adv_word, i_an_adv_word);
    wr(`REG_PCS_CTRL, 16'hffff);
    rc(`REG_PCS_CTRL, 16'h0800);
    check("force on", o_force_adv, 16'h0001);
    rc(`REG_ADV_WORD, `RST_ADV_WORD);
    wr(`REG_ADV_WORD, 16'ha5c3);
    rc(`REG_ADV_WORD, 16'ha5c3);
    check("adv forced", o_adv_word, 16'ha5c3);
    wr(`REG_PCS_CTRL, 16'h0000);
    #1 check("adv released", o_adv_word, i_an_adv_word);
    check("force off", o_force_adv, 16'h0000);
  endtask

  task automatic t_partner;
    @(posedge i_clk_sys);
    i_partner_word <= 16'h1111;
    i_partner_valid <= 1'b1;
    @(posedge i_clk_sys);
    i_partner_word <= 16'h2222;
    @(posedge i_clk_sys);
    i_partner_valid <= 1'b0;
    i_partner_word <= 16'h5555;
    wr(`REG_PARTNER_WORD, 16'hffff);
    rc(`REG_PARTNER_WORD, 16'h2222);
  endtask

  task automatic t_flags;
    @(posedge i_clk_sys);
    flg <= 4'hf;
    i_comma_pos <= 4'h9;
    @(posedge i_clk_sys);
    flg <= 4'h0;
    rc(`REG_LINK_FLAGS, 16'he980);
    rc(`REG_LINK_FLAGS, 16'h0900);
    i_comma_detect <= 1'b1;
    rc(`REG_LINK_FLAGS, 16'h1900);
    rc(`REG_LINK_FLAGS, 16'h1900);
  endtask

  task automatic t_select;
    logic [7:0] n;
    wr(`REG_BAD_CRC, 16'h7fff);
    rc(`REG_BAD_CRC, 16'h4000);
    for (int c = 0; c < 4; c++) begin
      wr(`REG_BAD_CRC, 16'(c << 14));
      pk(4'h2, 1);
      pk(4'h8, 2);
      n = (c == 0) ? 8'h01 : (c == 1) ? 8'h02 : 8'h00;
      rc(`REG_BAD_CRC, {2'(c), 6'h00, n});
      rc(`REG_GOOD_CRC, (c < 2) ? 16'h8000 : 16'h0000);
    end
    wr(`REG_BAD_CRC, 16'h0000);
  endtask

  task automatic t_count;
    i_media_link_up <= 1'b0;
    pk(4'h3, 3);
    rc(`REG_GOOD_CRC, 16'h0000);
    rc(`REG_BAD_CRC, 16'h0000);
    i_media_link_up <= 1'b1;
    pk(4'h1, 3);
    pk(4'h4, 2);
    rc(`REG_GOOD_CRC, 16'h8003);
    rc(`REG_GOOD_CRC, 16'h0000);
    pk(4'h2, 260);
    rc(`REG_BAD_CRC, 16'h00ff);
    pk(4'h2, 1);
    rc(`REG_BAD_CRC, 16'h0001);
    rc(`REG_GOOD_CRC, 16'h8000);
    pk(4'h1, 10001);
    rc(`REG_GOOD_CRC, 16'h8001);
  endtask

  task automatic t_page;
    logic [4:0] fa [5] = '{5'h10, 5'h15, 5'h1a, 5'h1d, 5'h05};
    wr(`REG_PAGE_SEL, `PAGE_EXT4);
    foreach (fa[i]) rc(fa[i], 16'hbeef);
    fw(5'h1e, `SPACE_P4_REFCLK);
    rc(5'h16, 16'h0000);
    rc(5'h19, 16'h0000);
    rc(`REG_PAGE_SEL, `PAGE_EXT4);
    wr(`REG_PAGE_SEL, `PAGE_MAIN);
    rc(`REG_ADV_WORD, 16'hbeef);
    fw(5'h1c, `SPACE_MAIN);
    rc(5'h16, 16'hbeef);
  endtask

  // --------------------------------------------------------------
  // Clock, watchdog and main sequence
  // --------------------------------------------------------------
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end

  // Longest scenario needs about 21000 cycles
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      complete_run();
    end
  end

  initial begin
    {i_wr, i_rd, i_partner_valid, i_comma_detect, flg, crc, i_comma_pos, i_addr} = '0;
    {i_wdata, i_partner_word} = '0;
    i_media_link_up = 1'b1;
    i_an_adv_word = 16'h3c5a;
    i_fwd_rdata = 16'hbeef;
    i_sys_rst = 1'b1;
    repeat (16) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    t_reset();
    t_adv();
    t_partner();
    t_flags();
    t_select();
    t_count();
    t_page();
    complete_run();
  end
endmodule
`default_nettype wire

// ===== rtl/crc_event_counter.v
// Clear-on-read event counter, wrapping or saturating at a top value
`default_nettype none

module crc_event_counter #(
  parameter             WIDTH    = 8,
  parameter [WIDTH-1:0] TOP      = {WIDTH{1'b1}},
  parameter             SATURATE = 1
) (
  input  wire             i_clk_sys,
  input  wire             i_sys_rst,
  input  wire             i_inc,
  input  wire             i_clr,
  output wire [WIDTH-1:0] o_count
);

  localparam [WIDTH-1:0] ONE  = {{(WIDTH-1){1'b0}}, 1'b1};
  localparam [WIDTH-1:0] ZERO = {WIDTH{1'b0}};

  reg [WIDTH-1:0] count_r;
  reg [WIDTH-1:0] count_nxt;

  // A packet in the read cycle starts the fresh count at one
  always @* begin
    count_nxt = count_r;
    if (i_clr)
      count_nxt = i_inc ? ONE : ZERO;
    else if (i_inc) begin
      if (count_r == TOP)
        count_nxt = SATURATE ? TOP : ZERO;
      else
        count_nxt = count_r + ONE;
    end
  end

  // State
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst)
      count_r <= ZERO;
    else
      count_r <= count_nxt;
  end

  assign o_count = count_r;

endmodule

`default_nettype wire

// ===== rtl/serdes_pcs_regs.vh
// Register map, field positions and reset values of the SerDes PCS status bank
`ifndef SERDES_PCS_REGS_VH
`define SERDES_PCS_REGS_VH

// ---------------------------------------------------------------------------
// Register indices (management address, 0..31)
// ---------------------------------------------------------------------------
`define REG_PAGED_LO      5'h10
`define REG_PCS_CTRL      5'h17
`define REG_ADV_WORD      5'h19
`define REG_PARTNER_WORD  5'h1a
`define REG_LINK_FLAGS    5'h1b
`define REG_GOOD_CRC      5'h1c
`define REG_BAD_CRC       5'h1d
`define REG_PAGE_SEL      5'h1f

// Page 4 decode boundaries
`define P4_CSR_LAST       5'h14
`define P4_PPS            5'h15
`define P4_RSVD_LAST      5'h19
`define P4_SPI_LAST       5'h1c

// ---------------------------------------------------------------------------
// Page select values
// ---------------------------------------------------------------------------
`define PAGE_MAIN         16'h0000
`define PAGE_EXT3         16'h0003
`define PAGE_EXT4         16'h0004

// ---------------------------------------------------------------------------
// Forwarded access space codes
// ---------------------------------------------------------------------------
`define SPACE_MAIN        3'h0
`define SPACE_EXT3_OTHER  3'h1
`define SPACE_P4_CSR      3'h2
`define SPACE_P4_PPS      3'h3
`define SPACE_P4_SPI      3'h4
`define SPACE_P4_REFCLK   3'h5
`define SPACE_OTHER_PAGE  3'h6

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define CTRL_FORCE_ADV    11
`define FLG_REALIGN       15
`define FLG_SIGDET        14
`define FLG_FEFI          13
`define FLG_COMMA         12
`define FLG_POS_HI        11
`define FLG_POS_LO        8
`define FLG_HLS           7
`define GOOD_SEEN         15
`define BAD_SEL_HI        15
`define BAD_SEL_LO        14

// ---------------------------------------------------------------------------
// Codes and reset values
// ---------------------------------------------------------------------------
`define SRC_FIBER         2'h0
`define SRC_MAC           2'h1
`define RST_ADV_WORD      16'h0000
`define RST_PARTNER_WORD  16'h0000
`define RST_PAGE_SEL      16'h0000
`define RST_SRC_SEL       2'h0
`define RST_FLAG          1'b0
`define GOOD_LAST         14'h270f
`define BAD_LAST          8'hff

`endif

// ===== rtl/serdes_pcs_status_counters.v
// Media SerDes PCS register bank: config words, status flags, CRC counters, paging
//
// Function
// [RULE1] Advertised word writable only while forced
// [RULE2] Unforced advertised read value is not dependable
// [RULE3] Partner word holds last received code
// [RULE4] Bit 15 comma realign, clears on read
// [RULE5] Bit 14 sticky signal detect, read clears
// [RULE6] Bit 13 latches far-end fault until read
// [RULE7] Bit 12 comma: clears missing, sets read
// [RULE8] Bits 11:8 show comma position 0-9
// [RULE9] Bit 7 latches halt line state until read
// [RULE10] Good bit 15 marks packet since read
// [RULE11] 14-bit good counter wraps at 10000
// [RULE12] Bits 15:14 select fiber or MAC source
// [RULE13] 8-bit bad counter saturates, read clears
// [RULE14] Counters run only while media link up
// [RULE15] Page 4 maps registers 16-30 to extended
// [RULE16] Registers 0-15 ignore page select
// [RULE17] Page 0 restores main registers 16-30
// [RULE18] Page 4 decodes CSR, PPS, SPI, refclk
// [RULE19] Control bit 11 forces advertised word
// [RULE20] Reserved bits read zero, ignore writes
`default_nettype none
`include "serdes_pcs_regs.vh"

module serdes_pcs_status_counters (
  input  wire        i_clk_sys,
  input  wire        i_sys_rst,
  // Register port
  input  wire [4:0]  i_addr,
  input  wire [15:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output wire [15:0] o_rdata,
  // Accesses outside this bank
  output wire        o_fwd_wr,
  output wire        o_fwd_rd,
  output wire [2:0]  o_fwd_space,
  output wire [4:0]  o_fwd_addr,
  output wire [15:0] o_fwd_wdata,
  input  wire [15:0] i_fwd_rdata,
  // PCS side
  input  wire [15:0] i_an_adv_word,
  output wire [15:0] o_adv_word,
  output wire        o_force_adv,
  input  wire        i_partner_valid,
  input  wire [15:0] i_partner_word,
  input  wire        i_comma_realign,
  input  wire        i_signal_detect,
  input  wire        i_fefi_rx,
  input  wire        i_comma_detect,
  input  wire [3:0]  i_comma_pos,
  input  wire        i_hls_rx,
  input  wire        i_media_link_up,
  input  wire        i_fiber_crc_good,
  input  wire        i_fiber_crc_bad,
  input  wire        i_mac_crc_good,
  input  wire        i_mac_crc_bad
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  reg  [15:0] page_sel_r;
  reg         force_adv_r;
  reg  [15:0] adv_word_r;
  reg  [15:0] partner_word_r;
  reg  [1:0]  src_sel_r;
  reg  [15:0] rdata_r;
  reg  [15:0] rdata_nxt;
  reg  [2:0]  space;
  wire        in_paged;
  wire        page3;
  wire        page4;
  wire        hit_page;
  wire        hit_ctrl;
  wire        hit_adv;
  wire        hit_partner;
  wire        hit_flags;
  wire        hit_good;
  wire        hit_bad;
  wire        hit_p4_rsvd;
  wire        own_hit;
  wire        rd_flags;
  wire        good_evt;
  wire        bad_evt;
  wire        flg_realign;
  wire        flg_sigdet;
  wire        flg_fefi;
  wire        flg_comma;
  wire        flg_hls;
  wire        good_seen;
  wire [13:0] good_count;
  wire [7:0]  bad_count;

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  // Only 16..30 follow the page; 0..15 and 31 never move
  assign in_paged    = (i_addr >= `REG_PAGED_LO) && (i_addr != `REG_PAGE_SEL); // [RULE16]
  assign page3       = (page_sel_r == `PAGE_EXT3);
  assign page4       = (page_sel_r == `PAGE_EXT4);                             // [RULE15]
  assign hit_page    = (i_addr == `REG_PAGE_SEL);
  assign hit_ctrl    = in_paged && page3 && (i_addr == `REG_PCS_CTRL);
  assign hit_adv     = in_paged && page3 && (i_addr == `REG_ADV_WORD);
  assign hit_partner = in_paged && page3 && (i_addr == `REG_PARTNER_WORD);
  assign hit_flags   = in_paged && page3 && (i_addr == `REG_LINK_FLAGS);
  assign hit_good    = in_paged && page3 && (i_addr == `REG_GOOD_CRC);
  assign hit_bad     = in_paged && page3 && (i_addr == `REG_BAD_CRC);
  // Reserved page 4 slots answer here with zero
  assign hit_p4_rsvd = in_paged && page4 && (i_addr > `P4_PPS) &&
                       (i_addr <= `P4_RSVD_LAST);                              // [RULE18]
  assign own_hit     = hit_page | hit_ctrl | hit_adv | hit_partner | hit_flags |
                       hit_good | hit_bad | hit_p4_rsvd;

  // Space code for accesses handed to the rest of the device
  always @* begin
    space = `SPACE_MAIN;                                                       // [RULE17]
    if (in_paged) begin
      if (page3)
        space = `SPACE_EXT3_OTHER;
      else if (page4) begin
        if (i_addr <= `P4_CSR_LAST)
          space = `SPACE_P4_CSR;                                               // [RULE18]
        else if (i_addr == `P4_PPS)
          space = `SPACE_P4_PPS;
        else if (i_addr <= `P4_SPI_LAST)
          space = `SPACE_P4_SPI;
        else
          space = `SPACE_P4_REFCLK;
      end else if (page_sel_r != `PAGE_MAIN)
        space = `SPACE_OTHER_PAGE;
    end
  end

  // Forwarding is combinational so foreign reads keep the one-cycle answer
  assign o_fwd_wr    = i_wr & ~own_hit;                                        // [RULE15]
  assign o_fwd_rd    = i_rd & ~own_hit;
  assign o_fwd_space = space;
  assign o_fwd_addr  = i_addr;
  assign o_fwd_wdata = i_wdata;

  // ---------------------------------------------------------------------------
  // Software-written registers
  // ---------------------------------------------------------------------------
  // Page select, force bit, advertised word, counter source
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      page_sel_r  <= `RST_PAGE_SEL;
      force_adv_r <= 1'b0;
      adv_word_r  <= `RST_ADV_WORD;
      src_sel_r   <= `RST_SRC_SEL;
    end else if (i_wr) begin
      if (hit_page)
        page_sel_r <= i_wdata;                                                 // [RULE15] [RULE17]
      if (hit_ctrl)
        force_adv_r <= i_wdata[`CTRL_FORCE_ADV];                               // [RULE19] [RULE20]
      if (hit_adv && force_adv_r)
        adv_word_r <= i_wdata;                                                 // [RULE1]
      if (hit_bad)
        src_sel_r <= i_wdata[`BAD_SEL_HI:`BAD_SEL_LO];                         // [RULE12]
    end
  end

  // Forced word overrides the negotiation engine's own word
  assign o_adv_word  = force_adv_r ? adv_word_r : i_an_adv_word;               // [RULE19]
  assign o_force_adv = force_adv_r;

  // ---------------------------------------------------------------------------
  // Link partner code word
  // ---------------------------------------------------------------------------
  // Holds the last word the PCS marks valid
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst)
      partner_word_r <= `RST_PARTNER_WORD;
    else if (i_partner_valid)
      partner_word_r <= i_partner_word;                                        // [RULE3]
  end

  // ---------------------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------------------
  assign rd_flags = i_rd & hit_flags;

  sticky_flag #(.RST_VAL(`RST_FLAG)) u_flag_realign (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_set     (i_comma_realign),                                              // [RULE4]
    .i_clr     (rd_flags),
    .o_flag    (flg_realign)
  );

  // Stays set while detect persists, since set wins over the read
  sticky_flag #(.RST_VAL(`RST_FLAG)) u_flag_sigdet (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_set     (i_signal_detect),                                              // [RULE5]
    .i_clr     (rd_flags),
    .o_flag    (flg_sigdet)
  );

  sticky_flag #(.RST_VAL(`RST_FLAG)) u_flag_fefi (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_set     (i_fefi_rx),                                                    // [RULE6]
    .i_clr     (rd_flags),
    .o_flag    (flg_fefi)
  );

  // Inverted sense: the read sets it, a missing comma clears it
  sticky_flag #(.RST_VAL(`RST_FLAG)) u_flag_comma (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_set     (rd_flags),                                                     // [RULE7]
    .i_clr     (~i_comma_detect),
    .o_flag    (flg_comma)
  );

  sticky_flag #(.RST_VAL(`RST_FLAG)) u_flag_hls (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_set     (i_hls_rx),                                                     // [RULE9]
    .i_clr     (rd_flags),
    .o_flag    (flg_hls)
  );

  // ---------------------------------------------------------------------------
  // Receive CRC counters
  // ---------------------------------------------------------------------------
  // Reserved source codes count nothing; link down freezes both counters
  assign good_evt = i_media_link_up &                                          // [RULE14]
                    (((src_sel_r == `SRC_FIBER) & i_fiber_crc_good) |
                     ((src_sel_r == `SRC_MAC) & i_mac_crc_good));              // [RULE12]
  assign bad_evt  = i_media_link_up &                                          // [RULE14]
                    (((src_sel_r == `SRC_FIBER) & i_fiber_crc_bad) |
                     ((src_sel_r == `SRC_MAC) & i_mac_crc_bad));

  sticky_flag #(.RST_VAL(`RST_FLAG)) u_good_seen (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_set     (good_evt | bad_evt),                                           // [RULE10]
    .i_clr     (i_rd & hit_good),
    .o_flag    (good_seen)
  );

  crc_event_counter #(.WIDTH(14), .TOP(`GOOD_LAST), .SATURATE(0)) u_good_cnt (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_inc     (good_evt),                                                     // [RULE11]
    .i_clr     (i_rd & hit_good),
    .o_count   (good_count)
  );

  crc_event_counter #(.WIDTH(8), .TOP(`BAD_LAST), .SATURATE(1)) u_bad_cnt (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_inc     (bad_evt),                                                      // [RULE13]
    .i_clr     (i_rd & hit_bad),
    .o_count   (bad_count)
  );

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  // Value captured at the read strobe, before that edge's clear-on-read
  always @* begin
    rdata_nxt = 16'h0000;                                                      // [RULE20]
    if (hit_page)
      rdata_nxt = page_sel_r;
    else if (hit_ctrl)
      rdata_nxt[`CTRL_FORCE_ADV] = force_adv_r;
    else if (hit_adv)
      rdata_nxt = force_adv_r ? adv_word_r : i_an_adv_word;                    // [RULE2]
    else if (hit_partner)
      rdata_nxt = partner_word_r;
    else if (hit_flags) begin
      rdata_nxt[`FLG_REALIGN]             = flg_realign;
      rdata_nxt[`FLG_SIGDET]              = flg_sigdet;
      rdata_nxt[`FLG_FEFI]                = flg_fefi;
      rdata_nxt[`FLG_COMMA]               = flg_comma;
      rdata_nxt[`FLG_POS_HI:`FLG_POS_LO]  = i_comma_pos;                       // [RULE8]
      rdata_nxt[`FLG_HLS]                 = flg_hls;
    end else if (hit_good) begin
      rdata_nxt[`GOOD_SEEN]               = good_seen;
      rdata_nxt[13:0]                     = good_count;
    end else if (hit_bad) begin
      rdata_nxt[`BAD_SEL_HI:`BAD_SEL_LO]  = src_sel_r;
      rdata_nxt[7:0]                      = bad_count;
    end else if (!hit_p4_rsvd)
      rdata_nxt = i_fwd_rdata;
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst)
      rdata_r <= 16'h0000;
    else
      rdata_r <= i_rd ? rdata_nxt : 16'h0000;
  end

  assign o_rdata = rdata_r;

endmodule

`default_nettype wire

// ===== rtl/sticky_flag.v
// Sticky status flag with set-over-clear priority
`default_nettype none

module sticky_flag #(
  parameter RST_VAL = 1'b0
) (
  input  wire i_clk_sys,
  input  wire i_sys_rst,
  input  wire i_set,
  input  wire i_clr,
  output wire o_flag
);

  reg flag_r;
  reg flag_nxt;

  // Set beats clear so an event in the clearing cycle survives
  always @* begin
    if (i_set)
      flag_nxt = 1'b1;
    else if (i_clr)
      flag_nxt = 1'b0;
    else
      flag_nxt = flag_r;
  end

  // State
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst)
      flag_r <= RST_VAL;
    else
      flag_r <= flag_nxt;
  end

  assign o_flag = flag_r;

endmodule

`default_nettype wire
